/* wor_pkg.sv */
// Constants for the wake timer: register map, field layout, reset values.
// Assumes a single clock and a plain byte-wide register port.
// Operation
// - High period byte at 0x1E, resets 0x87.
// - Low period byte at 0x1F, resets 0x6B.
// - Slow oscillator tick is clock divided 750.
// - Event 0 interval is count times resolution.
// - Event 1 follows Event 0 by coded delay.
// - Power-down bit 7 stops oscillator, resets 1.
// - Clearing power-down with bit 3 set starts an initial calibration.
// - Bit 3 enables calibration, resets to 1.
package wor_pkg;
  // ==========================================================
  // Register map
  localparam logic [5:0] WOR_ADDR_HIGH = 6'h1E;
  localparam logic [5:0] WOR_ADDR_LOW = 6'h1F;
  localparam logic [5:0] WOR_ADDR_CTRL = 6'h20;
  localparam logic [7:0] WOR_HIGH_RST = 8'h87;
  localparam logic [7:0] WOR_LOW_RST = 8'h6B;
  // ==========================================================
  // Control fields and reset values
  localparam int WOR_PD_BIT = 7;
  localparam int WOR_E1_LSB = 4;
  localparam int WOR_CAL_BIT = 3;
  localparam int WAKE_RESOLUTION_LSB = 0;
  localparam logic WOR_PD_RST = 1'b1;
  localparam logic [2:0] WOR_E1_RST = 3'h7;
  localparam logic WOR_CAL_RST = 1'b1;
  localparam logic [1:0] WAKE_RESOLUTION_RST = 2'h0;
  // ==========================================================
  // Timing
  localparam int WOR_RC_DIV = 750;
  localparam int WOR_CAL_TICKS = 4;
  // Event 1 delays in slow ticks, code 7 in the top slot.
  localparam logic [47:0] WOR_E1_TABLE = {6'h30, 6'h20, 6'h18, 6'h10,
                                          6'h0C, 6'h08, 6'h06, 6'h04};
  // Prescale terminal values for resolutions 3 down to 0.
  localparam logic [59:0] WAKE_RESOLUTION_TABLE = {15'h7FFF, 15'h03FF,
                                           15'h001F, 15'h0000};
  typedef enum logic [2:0] {
    WOR_OFF = 3'b001,
    WOR_CAL = 3'b010,
    WOR_RUN = 3'b100
  } wor_state_e;
endpackage : wor_pkg

/* wor_rc_tick.sv */
// Slow oscillator model: one-cycle enable every DIV clock cycles.
// Assumes enable_in is held low while the oscillator is powered down.
`timescale 1ns/10ps
module wor_rc_tick #(
  parameter int DIV = wor_pkg::WOR_RC_DIV
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic enable_in,
  output logic tick_out
);
  localparam logic [9:0] LAST = 10'(DIV - 1);
  logic [9:0] cnt_reg;

  // ==========================================================
  // Divider
  // divide by DIV, 750 by default.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || !enable_in) begin
      cnt_reg <= 10'h000;
      tick_out <= 1'b0;
    end else begin
      tick_out <= (cnt_reg == LAST);
      cnt_reg <= (cnt_reg == LAST) ? 10'h000 : cnt_reg + 10'h001;
    end
  end

  a_tick_spacing: assert property (@(posedge ref_clk_in)
    disable iff (rst_in)
    tick_out |-> $past(cnt_reg) == LAST)
    else $error("slow tick not at divider terminal");
endmodule : wor_rc_tick

/* wor_timer.sv */
// Wake timer top: registers, slow tick, calibration and event timing.
// Assumes register accesses are one-cycle strobes on ref_clk_in.
`timescale 1ns/10ps
module wor_timer #(
  parameter int RC_DIV = wor_pkg::WOR_RC_DIV,
  parameter int CAL_TICKS = wor_pkg::WOR_CAL_TICKS
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [5:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic wake_period_count_out,
  output logic settle_delay_select_out,
  output logic osc_running_out,
  output logic cal_busy_out
);
  logic [7:0] period_high_reg;
  logic [7:0] period_low_reg;
  logic slow_osc_powerdown_reg;
  logic [2:0] settle_delay_select_reg;
  logic slow_osc_cal_enable_reg;
  logic [1:0] wake_resolution_reg;
  wor_pkg::wor_state_e state_reg;
  logic [14:0] prescale_reg;
  logic [15:0] period_cnt_reg;
  logic [5:0] e1_cnt_reg;
  logic e1_pending_reg;
  logic [5:0] cal_cnt_reg;
  logic rc_tick;
  logic wr_high;
  logic wr_low;
  logic wr_ctrl;
  logic pd_clear;
  logic [15:0] wake_period_count;
  logic [15:0] period_last;
  logic [14:0] prescale_last;
  logic [5:0] e1_last;
  logic lsb_tick;
  logic period_hit;

  assign wr_high = reg_wr_in && (reg_addr_in == wor_pkg::WOR_ADDR_HIGH);
  assign wr_low = reg_wr_in && (reg_addr_in == wor_pkg::WOR_ADDR_LOW);
  assign wr_ctrl = reg_wr_in && (reg_addr_in == wor_pkg::WOR_ADDR_CTRL);
  assign pd_clear = wr_ctrl && slow_osc_powerdown_reg &&
                    !reg_wdata_in[wor_pkg::WOR_PD_BIT];
  assign wake_period_count = {period_high_reg, period_low_reg};
  assign period_last = (wake_period_count == 16'h0000) ? 16'h0000 :
                       wake_period_count - 16'h0001;
  assign prescale_last = wor_pkg::WAKE_RESOLUTION_TABLE[wake_resolution_reg*15 +: 15];
  assign e1_last = wor_pkg::WOR_E1_TABLE[settle_delay_select_reg*6 +: 6]
                   - 6'h01;
  assign lsb_tick = rc_tick && (state_reg == wor_pkg::WOR_RUN) &&
                    (prescale_reg == prescale_last);
  assign period_hit = lsb_tick && (period_cnt_reg == period_last);

  wor_rc_tick #(.DIV(RC_DIV)) i_wor_rc_tick (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .enable_in(!slow_osc_powerdown_reg),
    .tick_out(rc_tick)
  );

  // ==========================================================
  // Register file
  // high period byte.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      period_high_reg <= wor_pkg::WOR_HIGH_RST;
    end else if (wr_high) begin
      period_high_reg <= reg_wdata_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      period_low_reg <= wor_pkg::WOR_LOW_RST;
    end else if (wr_low) begin
      period_low_reg <= reg_wdata_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      slow_osc_powerdown_reg <= wor_pkg::WOR_PD_RST;
      settle_delay_select_reg <= wor_pkg::WOR_E1_RST;
      slow_osc_cal_enable_reg <= wor_pkg::WOR_CAL_RST;
      wake_resolution_reg <= wor_pkg::WAKE_RESOLUTION_RST;
    end else if (wr_ctrl) begin
      slow_osc_powerdown_reg <= reg_wdata_in[wor_pkg::WOR_PD_BIT];
      settle_delay_select_reg <= reg_wdata_in[wor_pkg::WOR_E1_LSB +: 3];
      slow_osc_cal_enable_reg <= reg_wdata_in[wor_pkg::WOR_CAL_BIT];
      wake_resolution_reg <= reg_wdata_in[wor_pkg::WAKE_RESOLUTION_LSB +: 2];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        wor_pkg::WOR_ADDR_HIGH: reg_rdata_out <= period_high_reg;
        wor_pkg::WOR_ADDR_LOW: reg_rdata_out <= period_low_reg;
        wor_pkg::WOR_ADDR_CTRL: reg_rdata_out <= {slow_osc_powerdown_reg,
          settle_delay_select_reg, slow_osc_cal_enable_reg, 1'b0,
          wake_resolution_reg};
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Oscillator state
  // calibrate on power-up when bit 3 of the control write is set, else go straight to run.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_reg <= wor_pkg::WOR_OFF;
      cal_cnt_reg <= 6'h00;
    end else if (wr_ctrl && reg_wdata_in[wor_pkg::WOR_PD_BIT]) begin
      state_reg <= wor_pkg::WOR_OFF;
    end else begin
      case (state_reg)
        wor_pkg::WOR_OFF: begin
          cal_cnt_reg <= 6'h00;
          if (pd_clear) begin
            state_reg <= reg_wdata_in[wor_pkg::WOR_CAL_BIT] ?
                         wor_pkg::WOR_CAL : wor_pkg::WOR_RUN;
          end
        end
        wor_pkg::WOR_CAL: begin
          if (rc_tick) begin
            cal_cnt_reg <= cal_cnt_reg + 6'h01;
            if (cal_cnt_reg == 6'(CAL_TICKS - 1)) begin
              state_reg <= wor_pkg::WOR_RUN;
            end
          end
        end
        wor_pkg::WOR_RUN: state_reg <= wor_pkg::WOR_RUN;
        default: state_reg <= wor_pkg::WOR_OFF;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      osc_running_out <= 1'b0;
      cal_busy_out <= 1'b0;
    end else begin
      osc_running_out <= !slow_osc_powerdown_reg;
      cal_busy_out <= (state_reg == wor_pkg::WOR_CAL);
    end
  end

  // ==========================================================
  // Event 0 timing
  // resolution prescale then period count.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || state_reg != wor_pkg::WOR_RUN) begin
      prescale_reg <= 15'h0000;
    end else if (rc_tick) begin
      prescale_reg <= (prescale_reg == prescale_last) ? 15'h0000 :
                      prescale_reg + 15'h0001;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in || state_reg != wor_pkg::WOR_RUN) begin
      period_cnt_reg <= 16'h0000;
      wake_period_count_out <= 1'b0;
    end else begin
      wake_period_count_out <= period_hit;
      if (period_hit) begin
        period_cnt_reg <= 16'h0000;
      end else if (lsb_tick) begin
        period_cnt_reg <= period_cnt_reg + 16'h0001;
      end
    end
  end

  // ==========================================================
  // Event 1 timing
  // coded delay after Event 0.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || state_reg != wor_pkg::WOR_RUN) begin
      e1_pending_reg <= 1'b0;
      e1_cnt_reg <= 6'h00;
      settle_delay_select_out <= 1'b0;
    end else begin
      settle_delay_select_out <= e1_pending_reg && rc_tick && (e1_cnt_reg == e1_last);
      if (wake_period_count_out) begin
        e1_pending_reg <= 1'b1;
        e1_cnt_reg <= 6'h00;
      end else if (e1_pending_reg && rc_tick) begin
        e1_cnt_reg <= e1_cnt_reg + 6'h01;
        if (e1_cnt_reg == e1_last) begin
          e1_pending_reg <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Checks
  a_high_reset_val: assert property (@(posedge ref_clk_in)
    rst_in |=> period_high_reg == wor_pkg::WOR_HIGH_RST)
    else $error("high period byte wrong after reset");
  a_low_reset_val: assert property (@(posedge ref_clk_in)
    rst_in |=> period_low_reg == wor_pkg::WOR_LOW_RST)
    else $error("low period byte wrong after reset");
  a_wake_period_count_at_terminal: assert property (@(posedge ref_clk_in)
    disable iff (rst_in)
    wake_period_count_out |-> $past(prescale_reg) == $past(prescale_last) &&
                   $past(period_cnt_reg) == $past(period_last))
    else $error("event 0 not at resolution and period terminal");
  a_settle_delay_select_delay: assert property (@(posedge ref_clk_in)
    disable iff (rst_in)
    settle_delay_select_out |-> $past(e1_cnt_reg) == $past(e1_last))
    else $error("event 1 delay count mismatch");
  a_powerdown_quiet: assert property (@(posedge ref_clk_in)
    disable iff (rst_in)
    slow_osc_powerdown_reg |=> !rc_tick && !wake_period_count_out)
    else $error("activity while oscillator powered down");
  a_cal_on_wake: assert property (@(posedge ref_clk_in)
    disable iff (rst_in)
    pd_clear && reg_wdata_in[wor_pkg::WOR_CAL_BIT] |=> ##1 cal_busy_out)
    else $error("calibration did not start on power-up");
  a_cal_skipped: assert property (@(posedge ref_clk_in)
    disable iff (rst_in)
    pd_clear && !reg_wdata_in[wor_pkg::WOR_CAL_BIT] |=> ##1 !cal_busy_out)
    else $error("calibration ran while disabled");
  a_reserved_zero: assert property (@(posedge ref_clk_in)
    disable iff (rst_in)
    reg_rd_in && reg_addr_in == wor_pkg::WOR_ADDR_CTRL |=>
    !reg_rdata_out[2])
    else $error("reserved control bit read nonzero");
  a_period_restart: assert property (@(posedge ref_clk_in)
    disable iff (rst_in)
    wake_period_count_out |-> period_cnt_reg == 16'h0000)
    else $error("period count not restarted after event 0");
endmodule : wor_timer

/* wake_on_radio_timer_tb.sv */
// Self-checking bench for the wake timer: registers, event timing, stop.
// Assumes wor_pkg and wor_timer are compiled first; shortened RC divider.
`timescale 1ns/10ps
module wake_on_radio_timer_tb;
  localparam int DIV = 4;
  localparam int CALT = 1;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [5:0] reg_addr_in = 6'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic wake_period_count_out;
  logic settle_delay_select_out;
  logic osc_running_out;
  logic cal_busy_out;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  logic [7:0] rnd = 8'h4E;
  int cal_cyc = 0;

  wor_timer #(.RC_DIV(DIV), .CAL_TICKS(CALT)) i_wor_timer (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out),
    .wake_period_count_out(wake_period_count_out),
    .settle_delay_select_out(settle_delay_select_out),
    .osc_running_out(osc_running_out),
    .cal_busy_out(cal_busy_out)
  );

  // ==========================================================
  // Clock, cycle count and helpers
  always #50 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cal_busy_out === 1'b1) cal_cyc <= cal_cyc + 1;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  function automatic int e1_ticks(input int c);
    case (c)
      0: return 4;
      1: return 6;
      2: return 8;
      3: return 12;
      4: return 16;
      5: return 24;
      6: return 32;
      default: return 48;
    endcase
  endfunction : e1_ticks

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    d = reg_rdata_out;
  endtask : rd

  task automatic wait_e(input bit sel, input int lim, output int t);
    t = -1;
    for (int i = 0; i < lim; i++) begin
      @(posedge ref_clk_in);
      #1;
      if ((sel ? settle_delay_select_out : wake_period_count_out) === 1'b1) begin
        t = cyc;
        break;
      end
    end
  endtask : wait_e

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  // ==========================================================
  // Watchdog
  initial begin
    #4000000;
    fail_count++;
    results();
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] d;
    logic [7:0] v;
    logic [15:0] n;
    int res;
    int code;
    int mult;
    int t0;
    int t1;
    int t2;
    bit cal;
    int c0;
    repeat (5) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rd(wor_pkg::WOR_ADDR_HIGH, d);
    chk(d, 8'h87);
    rd(wor_pkg::WOR_ADDR_LOW, d);
    chk(d, 8'h6B);
    rd(wor_pkg::WOR_ADDR_CTRL, d);
    chk(d, 8'hF8);
    rd(6'h3F, d);
    chk(d, 8'h00);
    $display("test reset values done");
    rnd = lfsr(rnd);
    wr(wor_pkg::WOR_ADDR_HIGH, rnd);
    rd(wor_pkg::WOR_ADDR_HIGH, d);
    chk(d, rnd);
    rnd = lfsr(rnd);
    wr(wor_pkg::WOR_ADDR_LOW, rnd);
    rd(wor_pkg::WOR_ADDR_LOW, d);
    chk(d, rnd);
    v = lfsr(rnd) | 8'h84;
    wr(wor_pkg::WOR_ADDR_CTRL, v);
    rd(wor_pkg::WOR_ADDR_CTRL, d);
    chk(d, v & 8'hFB);
    chk(osc_running_out, 1'b0);
    $display("test register access done");
    // every delay code, three resolutions, one calibrated start.
    for (int k = 0; k < 10; k++) begin
      rnd = lfsr(rnd);
      code = k % 8;
      res = (k < 8) ? 0 : k - 7;
      mult = 1 << (5 * res);
      n = (res == 0) ? 16'(49 + rnd[4:0]) : ((res == 1) ? 16'h0002 : 16'h0001);
      cal = (k == 3);
      wr(wor_pkg::WOR_ADDR_HIGH, n[15:8]);
      wr(wor_pkg::WOR_ADDR_LOW, n[7:0]);
      c0 = cal_cyc;
      wr(wor_pkg::WOR_ADDR_CTRL, {1'b0, 3'(code), cal, 1'b0, 2'(res)});
      @(posedge ref_clk_in);
      #1;
      chk(osc_running_out, 1'b1);
      wait_e(1'b0, n * mult * DIV + DIV * CALT * 4 + 40, t0);
      chk(cal_cyc - c0, cal ? CALT * DIV + 1 : 0);
      wait_e(1'b1, 50 * DIV, t1);
      chk(t1 - t0, e1_ticks(code) * DIV);
      wait_e(1'b0, n * mult * DIV + 10, t2);
      chk(t2 - t0, n * mult * DIV);
      wr(wor_pkg::WOR_ADDR_CTRL, 8'h80);
      @(posedge ref_clk_in);
      #1;
      chk(osc_running_out, 1'b0);
      wait_e(1'b0, 300, t2);
      chk(t2, -1);
      $display("test run %0d done", k);
    end
    wr(wor_pkg::WOR_ADDR_CTRL, 8'h00);
    wait_e(1'b0, 40, t0);
    chk(t0 != -1, 1'b1);
    @(posedge ref_clk_in);
    rst_in <= 1'b1;
    repeat (5) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rd(wor_pkg::WOR_ADDR_HIGH, d);
    chk(d, 8'h87);
    rd(wor_pkg::WOR_ADDR_LOW, d);
    chk(d, 8'h6B);
    rd(wor_pkg::WOR_ADDR_CTRL, d);
    chk(d, 8'hF8);
    chk(osc_running_out, 1'b0);
    wait_e(1'b0, 300, t2);
    chk(t2, -1);
    $display("test mid-run reset done");
    results();
  end
endmodule : wake_on_radio_timer_tb
